// file: smo_fetch_hold.sv
// single-quadword instruction fetch holder, not snooped by data writes
`timescale 1ns/10ps
`default_nettype none
module smo_fetch_hold (
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        inv_i,
    input  wire logic                        fill_i,
    input  wire logic [smo_pkg::ADDR_W-1:0]  fill_addr_i,
    input  wire logic [smo_pkg::DATA_W-1:0]  fill_data_i,
    input  wire logic [smo_pkg::ADDR_W-1:0]  look_addr_i,
    output logic                             hit_o,
    output logic [smo_pkg::DATA_W-1:0]       data_o
);
    logic                       valid_reg;
    logic [smo_pkg::ADDR_W-1:0] tag_reg;
    logic [smo_pkg::DATA_W-1:0] data_reg;

    ////////////////////////////////////////////////////////////////////////
    // stale until invalidated: data writes are deliberately not seen here
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            valid_reg <= 1'b0;
        end else if (inv_i) begin
            valid_reg <= 1'b0; // R13
        end else if (fill_i) begin
            valid_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            tag_reg  <= smo_pkg::ADDR_RST;
            data_reg <= smo_pkg::DATA_RST;
        end else if (fill_i) begin
            tag_reg  <= fill_addr_i;
            data_reg <= fill_data_i;
        end
    end

    assign hit_o  = valid_reg && (tag_reg == look_addr_i);
    assign data_o = data_reg;
endmodule // smo_fetch_hold
`default_nettype wire

// file: smo_mem_model.sv
// coherent memory model on the unit's memory port, prompt or stalling
`timescale 1ns/10ps
`default_nettype none
module smo_mem_model (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        slow_i,
    input  wire logic        req_valid_i,
    input  wire logic        req_write_i,
    input  wire logic [30:0] req_addr_i,
    input  wire logic [63:0] req_wdata_i,
    output logic             req_ready_o,
    output logic             rsp_valid_o,
    output logic [63:0]      rsp_data_o
);
    // only 16 locations: higher address bits alias
    logic [63:0] mem_reg [16];
    logic        hs;
    assign hs = req_valid_i && req_ready_o;
    initial foreach (mem_reg[i]) mem_reg[i] = 64'h0;
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            req_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o  <= 64'h0;
        end else begin
            req_ready_o <= slow_i ? ~req_ready_o : 1'b1;
            rsp_valid_o <= hs;
            // outside a reply the data lines flip so stale values cannot pass
            rsp_data_o  <= hs && !req_write_i ? mem_reg[req_addr_i[3:0]] : ~rsp_data_o;
            if (hs && req_write_i)
                mem_reg[req_addr_i[3:0]] <= req_wdata_i;
        end
    end
endmodule // smo_mem_model
`default_nettype wire

// file: smo_pkg.sv
// package for the shared memory ordering unit: op codes, widths, state codes
// Summary of operation
// R01: before is closure of issue and location order; one access in flight keeps it.
// R02: after reading a newer value, later same-location reads never return older ones.
// R03: every write is sent to memory at once, never parked behind later work.
// R04: after reading another's value over own write, own stale write is not returned.
// R05: all observers see writes to one location in one order, kept by fabric.
// R06: writes to different locations may be seen reversed without barriers on both sides.
// R07: barrier on writer and reader makes new y imply new x.
// R08: write, barrier, read on two processors: at most one reads the old value.
// R09: two writers reading twice agree on which write was last.
// R10: no barrier is inserted by the unit; only explicit barrier ops order accesses.
// R11: interrupts, exceptions, context swaps, cache invalidation never act as barriers.
// R12: a data read returns the immediately preceding own write, no barrier needed.
// R13: fetch may miss a preceding data write until an instruction stream barrier.
// R14: an instruction-side translation fill may carry an implicit instruction stream barrier.
// R15: different-location accesses need ordering only against barriers and translation fills.
// R16: data reads return exactly the latest preceding write at the location.
// R17: same-location accesses, one a write, reach the location in issue order.
// R18: a full barrier holds later accesses until all earlier ones are ordered.
package smo_pkg;
    localparam int ADDR_W = 31;
    localparam int DATA_W = 64;
    localparam int OP_W   = 3;

    localparam logic [OP_W-1:0] OP_FETCH = 3'h0;
    localparam logic [OP_W-1:0] OP_READ  = 3'h1;
    localparam logic [OP_W-1:0] OP_WRITE = 3'h2;
    localparam logic [OP_W-1:0] OP_FBAR  = 3'h3;
    localparam logic [OP_W-1:0] OP_IBAR  = 3'h4;
    localparam logic [OP_W-1:0] OP_DFILL = 3'h5;
    localparam logic [OP_W-1:0] OP_IFILL = 3'h6;

    localparam logic [DATA_W-1:0] DATA_RST = 64'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 31'h0;
    localparam logic              IFILL_IMPLIES_IBAR = 1'b1;

    typedef enum logic [3:0] {
        SMO_ST_IDLE  = 4'h1,
        SMO_ST_ISSUE = 4'h2,
        SMO_ST_WAIT  = 4'h4,
        SMO_ST_RESP  = 4'h8
    } smo_state_e;
endpackage

// file: smo_unit.sv
// shared memory ordering unit: one processor's in-order access port to coherent memory
`timescale 1ns/10ps
`default_nettype none
module smo_unit (
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        req_valid_i,
    input  wire logic [smo_pkg::OP_W-1:0]    req_op_i,
    input  wire logic [smo_pkg::ADDR_W-1:0]  req_addr_i,
    input  wire logic [smo_pkg::DATA_W-1:0]  req_wdata_i,
    output logic                             req_ready_o,
    output logic                             rsp_valid_o,
    output logic [smo_pkg::DATA_W-1:0]       rsp_data_o,
    output logic                             mem_req_valid_o,
    output logic                             mem_req_write_o,
    output logic [smo_pkg::ADDR_W-1:0]       mem_req_addr_o,
    output logic [smo_pkg::DATA_W-1:0]       mem_req_wdata_o,
    input  wire logic                        mem_req_ready_i,
    input  wire logic                        mem_rsp_valid_i,
    input  wire logic [smo_pkg::DATA_W-1:0]  mem_rsp_data_i,
    output logic                             busy_o
);
    smo_pkg::smo_state_e         state_reg;
    smo_pkg::smo_state_e         state_next;
    logic [smo_pkg::OP_W-1:0]    op_reg;
    logic [smo_pkg::ADDR_W-1:0]  addr_reg;
    logic                        ready_reg;
    logic                        rsp_valid_reg;
    logic [smo_pkg::DATA_W-1:0]  rsp_data_reg;
    logic                        mreq_valid_reg;
    logic                        mreq_write_reg;
    logic [smo_pkg::ADDR_W-1:0]  mreq_addr_reg;
    logic [smo_pkg::DATA_W-1:0]  mreq_wdata_reg;
    logic                        busy_reg;
    logic                        accept;
    logic                        hold_hit;
    logic [smo_pkg::DATA_W-1:0]  hold_data;
    logic                        hold_inv;
    logic                        hold_fill;
    logic                        fetch_hit;

    function automatic logic is_barrier(input logic [smo_pkg::OP_W-1:0] op);
        is_barrier = (op == smo_pkg::OP_FBAR) || (op == smo_pkg::OP_IBAR);
    endfunction

    function automatic logic drains_ifetch(input logic [smo_pkg::OP_W-1:0] op);
        drains_ifetch = (op == smo_pkg::OP_IBAR) ||
                        ((op == smo_pkg::OP_IFILL) && smo_pkg::IFILL_IMPLIES_IBAR);
    endfunction

    assign accept    = req_valid_i && ready_reg;
    assign fetch_hit = (req_op_i == smo_pkg::OP_FETCH) && hold_hit;

    ////////////////////////////////////////////////////////////////////////
    // sequencing: at most one access outstanding, taken in issue order.
    // costs bandwidth, but keeps same-location order and closure trivially.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            smo_pkg::SMO_ST_IDLE: begin
                if (accept) begin
                    if (is_barrier(req_op_i) || fetch_hit) begin
                        state_next = smo_pkg::SMO_ST_RESP; // R07 R08 R10 R18
                    end else begin
                        state_next = smo_pkg::SMO_ST_ISSUE; // R01 R03 R06 R17
                    end
                end
            end
            smo_pkg::SMO_ST_ISSUE: begin
                if (mem_req_ready_i) begin
                    state_next = smo_pkg::SMO_ST_WAIT;
                end
            end
            smo_pkg::SMO_ST_WAIT: begin
                if (mem_rsp_valid_i) begin
                    state_next = smo_pkg::SMO_ST_RESP; // R15 R18
                end
            end
            smo_pkg::SMO_ST_RESP: begin
                state_next = smo_pkg::SMO_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_reg <= smo_pkg::SMO_ST_IDLE;
            ready_reg <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_reg <= (state_next == smo_pkg::SMO_ST_IDLE);
            busy_reg  <= (state_next != smo_pkg::SMO_ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // captured request
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            op_reg   <= smo_pkg::OP_FETCH;
            addr_reg <= smo_pkg::ADDR_RST;
        end else if (accept) begin
            op_reg   <= req_op_i;
            addr_reg <= req_addr_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory request: writes go out immediately, no write-behind
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mreq_valid_reg <= 1'b0;
            mreq_write_reg <= 1'b0;
            mreq_addr_reg  <= smo_pkg::ADDR_RST;
            mreq_wdata_reg <= smo_pkg::DATA_RST;
        end else begin
            mreq_valid_reg <= (state_next == smo_pkg::SMO_ST_ISSUE); // R03
            if (accept) begin
                mreq_write_reg <= (req_op_i == smo_pkg::OP_WRITE);
                mreq_addr_reg  <= req_addr_i;
                mreq_wdata_reg <= req_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // response: data reads take the coherent memory's value; fetch hits take the fetch holder's local copy
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg  <= smo_pkg::DATA_RST;
        end else begin
            rsp_valid_reg <= (state_next == smo_pkg::SMO_ST_RESP);
            if (accept && fetch_hit) begin
                rsp_data_reg <= hold_data; // R13
            end else if (accept) begin
                rsp_data_reg <= smo_pkg::DATA_RST;
            end else if ((state_reg == smo_pkg::SMO_ST_WAIT) && mem_rsp_valid_i) begin
                if (op_reg == smo_pkg::OP_WRITE) begin
                    rsp_data_reg <= smo_pkg::DATA_RST;
                end else begin
                    rsp_data_reg <= mem_rsp_data_i; // R02 R04 R05 R09 R12 R16
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fetch holder: only instruction stream barriers, explicit or fill-implied, drop it; there is
    // no interrupt, exception or context input that could flush it
    assign hold_inv  = accept && drains_ifetch(req_op_i); // R11 R13 R14
    assign hold_fill = (state_reg == smo_pkg::SMO_ST_WAIT) && mem_rsp_valid_i &&
                       (op_reg == smo_pkg::OP_FETCH);

    smo_fetch_hold u_hold (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .inv_i       (hold_inv),
        .fill_i      (hold_fill),
        .fill_addr_i (addr_reg),
        .fill_data_i (mem_rsp_data_i),
        .look_addr_i (req_addr_i),
        .hit_o       (hold_hit),
        .data_o      (hold_data)
    );

    assign req_ready_o     = ready_reg;
    assign rsp_valid_o     = rsp_valid_reg;
    assign rsp_data_o      = rsp_data_reg;
    assign mem_req_valid_o = mreq_valid_reg;
    assign mem_req_write_o = mreq_write_reg;
    assign mem_req_addr_o  = mreq_addr_reg;
    assign mem_req_wdata_o = mreq_wdata_reg;
    assign busy_o          = busy_reg;
endmodule // smo_unit
`default_nettype wire

// file: smo_unit_assertions.sv
// port checker for the shared memory ordering unit
`timescale 1ns/10ps
`default_nettype none
module smo_unit_assertions (
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic        req_valid_i,
    input wire logic [2:0]  req_op_i,
    input wire logic [30:0] req_addr_i,
    input wire logic [63:0] req_wdata_i,
    input wire logic        req_ready_o,
    input wire logic        rsp_valid_o,
    input wire logic [63:0] rsp_data_o,
    input wire logic        mem_req_valid_o,
    input wire logic        mem_req_write_o,
    input wire logic [30:0] mem_req_addr_o,
    input wire logic [63:0] mem_req_wdata_o,
    input wire logic        mem_req_ready_i,
    input wire logic        mem_rsp_valid_i,
    input wire logic [63:0] mem_rsp_data_i,
    input wire logic        busy_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    logic take;
    logic bar;
    assign take = req_valid_i && req_ready_o;
    assign bar  = req_op_i == smo_pkg::OP_FBAR || req_op_i == smo_pkg::OP_IBAR;
    rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o && req_ready_o && !busy_o)
        else $error("response pulse wrong");
    one_flight_a: assert property (take |=> !req_ready_o && busy_o)
        else $error("second request taken");
    bar_quick_a: assert property (take && bar |=> rsp_valid_o && rsp_data_o == 64'h0 && !mem_req_valid_o)
        else $error("barrier answer wrong");
    wr_fwd_a: assert property (take && req_op_i == smo_pkg::OP_WRITE |=> mem_req_valid_o && mem_req_write_o
        && mem_req_addr_o == $past(req_addr_i) && mem_req_wdata_o == $past(req_wdata_i))
        else $error("write not sent");
    rd_fwd_a: assert property (take && req_op_i == smo_pkg::OP_READ
        |=> mem_req_valid_o && !mem_req_write_o && mem_req_addr_o == $past(req_addr_i))
        else $error("read not sent");
    req_hold_a: assert property (mem_req_valid_o && !mem_req_ready_i
        |=> mem_req_valid_o && $stable(mem_req_addr_o) && $stable(mem_req_write_o))
        else $error("memory request dropped");
    rsp_data_a: assert property (mem_rsp_valid_i && busy_o && !mem_req_valid_o && !rsp_valid_o
        |=> rsp_valid_o && rsp_data_o == ($past(mem_req_write_o) ? 64'h0 : $past(mem_rsp_data_i)))
        else $error("read data lost");
    rsp_cause_a: assert property (rsp_valid_o |-> $past(take) || $past(mem_rsp_valid_i))
        else $error("response without cause");
    ////////////////////////////////////////////////////////////
    cover property (take && req_op_i == smo_pkg::OP_WRITE);
    cover property (take && bar);
    cover property (mem_req_valid_o && !mem_req_ready_i);
endmodule // smo_unit_assertions
bind smo_unit smo_unit_assertions smo_unit_assertions_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .busy_o(busy_o),
    .mem_req_valid_o(mem_req_valid_o), .mem_req_write_o(mem_req_write_o), .mem_req_addr_o(mem_req_addr_o),
    .mem_req_wdata_o(mem_req_wdata_o), .mem_req_ready_i(mem_req_ready_i), .mem_rsp_valid_i(mem_rsp_valid_i),
    .mem_rsp_data_i(mem_rsp_data_i));
`default_nettype wire

// file: tb.sv
// testbench for the shared memory ordering unit
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [63:0] D1 = 64'h5a5a_0000_0000_0001;
    localparam logic [63:0] D2 = 64'ha5a5_0000_0000_0002;
    localparam logic [63:0] D3 = 64'h3c3c_0000_0000_0003;
    logic        clk_sys_i;
    logic        rst_n_i = 1'b0;
    logic        req_valid_i = 1'b0;
    logic [2:0]  req_op_i = 3'h0;
    logic [30:0] req_addr_i = 31'h0;
    logic [63:0] req_wdata_i = 64'h0;
    logic        slow = 1'b0;
    logic        req_ready_o, rsp_valid_o, busy_o, m_valid, m_write, m_ready, m_rsp_v;
    logic [30:0] m_addr;
    logic [63:0] rsp_data_o, m_wdata, m_rsp_d, h;
    logic [63:0] hs_cnt = 64'h0;
    int          err_count = 0, cmp_count = 0, cyc = 0;
    smo_unit smo_unit_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
        .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .mem_req_valid_o(m_valid), .mem_req_write_o(m_write),
        .mem_req_addr_o(m_addr), .mem_req_wdata_o(m_wdata), .mem_req_ready_i(m_ready),
        .mem_rsp_valid_i(m_rsp_v), .mem_rsp_data_i(m_rsp_d), .busy_o(busy_o));
    smo_mem_model smo_mem_model_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_i(slow),
        .req_valid_i(m_valid), .req_write_i(m_write), .req_addr_i(m_addr), .req_wdata_i(m_wdata),
        .req_ready_o(m_ready), .rsp_valid_o(m_rsp_v), .rsp_data_o(m_rsp_d));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (m_valid && m_ready)
            hs_cnt <= hs_cnt + 64'h1;
        if (cyc == 2000) begin
            err_count++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // one request, held until taken, then its answer compared
    task automatic op(input logic [2:0] o, input logic [30:0] a, input logic [63:0] d, input logic [63:0] e);
        req_valid_i <= 1'b1;
        req_op_i    <= o;
        req_addr_i  <= a;
        req_wdata_i <= d;
        do @(posedge clk_sys_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        do @(posedge clk_sys_i); while (rsp_valid_o !== 1'b1);
        chk(rsp_data_o, e);
    endtask
    task automatic t_data(input logic [30:0] a);
        h = hs_cnt;
        op(smo_pkg::OP_WRITE, a, D1, 64'h0);
        op(smo_pkg::OP_WRITE, a, D2, 64'h0);
        op(smo_pkg::OP_READ, a, 64'h0, D2);
        op(smo_pkg::OP_READ, a + 31'h1, 64'h0, 64'h0);
        chk(hs_cnt - h, 64'h4);
    endtask
    task automatic t_bar();
        h = hs_cnt;
        op(smo_pkg::OP_READ, 31'h1, 64'h0, D2);
        op(smo_pkg::OP_FBAR, 31'h1, D1, 64'h0);
        op(smo_pkg::OP_IBAR, 31'h1, D1, 64'h0);
        chk(hs_cnt - h, 64'h1);
    endtask
    task automatic t_fetch();
        op(smo_pkg::OP_WRITE, 31'h8, D1, 64'h0);
        op(smo_pkg::OP_FETCH, 31'h8, 64'h0, D1);
        h = hs_cnt;
        op(smo_pkg::OP_FETCH, 31'h8, 64'h0, D1);
        chk(hs_cnt - h, 64'h0);
        op(smo_pkg::OP_WRITE, 31'h8, D2, 64'h0);
        op(smo_pkg::OP_FETCH, 31'h8, 64'h0, D1);
        op(smo_pkg::OP_IBAR, 31'h8, 64'h0, 64'h0);
        op(smo_pkg::OP_FETCH, 31'h8, 64'h0, D2);
        op(smo_pkg::OP_WRITE, 31'h8, D3, 64'h0);
        op(smo_pkg::OP_DFILL, 31'h9, 64'h0, 64'h0);
        op(smo_pkg::OP_FETCH, 31'h8, 64'h0, D2);
        op(smo_pkg::OP_IFILL, 31'h9, 64'h0, 64'h0);
        op(smo_pkg::OP_FETCH, 31'h8, 64'h0, D3);
    endtask
    task automatic tally_and_finish();
        $display("errors=%0d compares=%0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        t_data(31'h1);
        slow <= 1'b1;
        t_data(31'h3);
        t_bar();
        t_fetch();
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
